// ---- logic/gpm_pkg.sv ----
// Package for the six-pin port function multiplexer
package gpm_pkg;

  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int          NUM_PINS     = 6;
  localparam logic [5:0]  DATA_RST     = 6'h00;
  localparam logic [5:0]  DIR_RST      = 6'h00;
  localparam logic [5:0]  PULL_RST     = 6'h00;
  localparam logic [5:0]  WAKE_RST     = 6'h00;
  localparam logic [1:0]  STRAP_DEBUG  = 2'h1;
  localparam logic [1:0]  STRAP_PROG   = 2'h2;

  // ----------------------------------------
  // Pin positions
  // ----------------------------------------
  localparam int PIN_TW_CLK  = 0;
  localparam int PIN_TW_DAT  = 1;
  localparam int PIN_SEL     = 2;
  localparam int PIN_TX      = 3;
  localparam int PIN_RX      = 4;
  localparam int PIN_SCK     = 5;

  typedef enum logic [1:0] {
    GPM_BOOT_NORMAL = 2'b00,
    GPM_BOOT_DEBUG  = 2'b01,
    GPM_BOOT_PROG   = 2'b10
  } gpm_boot_t;

  typedef enum logic [1:0] {
    GPM_ST_SAMPLE = 2'b00,
    GPM_ST_RUN    = 2'b01
  } gpm_state_t;

  // Software configuration of the port
  typedef struct packed {
    logic [5:0] data;
    logic [5:0] dir_out;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
    logic [5:0] wake_en;
  } gpm_cfg_t;

  // Alternate function enables
  typedef struct packed {
    logic twowire_port_enable;
    logic uart_en;
    logic uart_mode0;
    logic spi_en;
    logic spi_master;
    logic spi_dma;
    logic pulse_timer_en;
    logic radio_tx_pin_enable;
    logic test_en;
  } gpm_func_t;

  // Outputs of on-chip peripherals toward pins
  typedef struct packed {
    logic tw_clk_oe_n;
    logic tw_dat_oe_n;
    logic uart_txd;
    logic uart_rxclk;
    logic spi_sel;
    logic spi_mosi;
    logic spi_miso;
    logic spi_sck;
    logic pulse_channel_zero;
    logic pulse_channel_one;
    logic radio_bit;
    logic test_out_zero;
    logic test_out_one;
  } gpm_periph_t;

  // Pin levels delivered to peripherals
  typedef struct packed {
    logic tw_clk;
    logic tw_dat;
    logic uart_rxd;
    logic spi_sel;
    logic spi_mosi;
    logic spi_miso;
    logic spi_sck;
    logic external_system_clock_in;
  } gpm_pin_in_t;

endpackage

// ---- logic/gpm_port_mux.sv ----
// Six-pin port with alternate function multiplexing and boot strap
`timescale 1ns/1ns
module gpm_port_mux (
  input  wire logic                 CORE_CLK,
  input  wire logic                 NRST,
  input  wire gpm_pkg::gpm_cfg_t    CFG_WR_DATA,
  input  wire logic                 CFG_WR,
  input  wire logic                 LOW_POWER,
  input  wire gpm_pkg::gpm_func_t   FUNC,
  input  wire gpm_pkg::gpm_periph_t PERIPH,
  input  wire logic [5:0]           PIN_IN,
  output logic [5:0]                PIN_OUT,
  output logic [5:0]                PIN_OE_N,
  output logic [5:0]                PIN_PULL_UP,
  output logic [5:0]                PIN_PULL_DOWN,
  output gpm_pkg::gpm_cfg_t         CFG_RD_DATA,
  output logic [5:0]                PIN_STATE,
  output gpm_pkg::gpm_pin_in_t      PERIPH_IN,
  output logic [1:0]                BOOT_MODE,
  output logic                      BOOT_VALID,
  output logic                      WAKE
);
  import gpm_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      prev_r  <= 6'h00;
    end else begin
      sync1_r <= PIN_IN;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ----------------------------------------
  // Configuration store
  // ----------------------------------------
  gpm_cfg_t cfg_r;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= '{DATA_RST, DIR_RST, PULL_RST, PULL_RST, WAKE_RST};
    end else if (CFG_WR && !LOW_POWER) begin
      cfg_r <= CFG_WR_DATA;
    end
  end

  // ----------------------------------------
  // Boot strap sampling
  // ----------------------------------------
  gpm_state_t state_r;
  logic [1:0] boot_r;
  logic [1:0] settle_r;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r  <= GPM_ST_SAMPLE;
      boot_r   <= GPM_BOOT_NORMAL;
      settle_r <= 2'h0;
    end else begin
      case (state_r)
        GPM_ST_SAMPLE: begin
          // Wait for two-stage synchroniser to fill
          if (settle_r == 2'h2) begin
            state_r <= GPM_ST_RUN;
            if (sync2_r[1:0] == STRAP_DEBUG) begin
              boot_r <= GPM_BOOT_DEBUG;
            end else if (sync2_r[1:0] == STRAP_PROG) begin
              boot_r <= GPM_BOOT_PROG;
            end else begin
              boot_r <= GPM_BOOT_NORMAL;
            end
          end else begin
            settle_r <= settle_r + 2'h1;
          end
        end
        GPM_ST_RUN: state_r <= GPM_ST_RUN;
        default:    state_r <= GPM_ST_SAMPLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pin function selection
  // ----------------------------------------
  logic [5:0] out_nxt;
  logic [5:0] drv_nxt;
  logic [5:0] pu_nxt;

  // ----------------------------------------
  // Pin claim decoding
  // ----------------------------------------
  // High when a higher-priority function owns pins 3 and 4
  function automatic logic mid_pins_taken(input gpm_func_t f);
    mid_pins_taken = f.test_en || f.spi_en || f.uart_en;
  endfunction

  always_comb begin
    out_nxt = cfg_r.data;
    drv_nxt = cfg_r.dir_out;
    pu_nxt  = cfg_r.pull_up;
    if (FUNC.twowire_port_enable) begin
      // Open drain: drive low only; pull-up kept from software
      out_nxt[PIN_TW_CLK] = 1'b0;
      drv_nxt[PIN_TW_CLK] = !PERIPH.tw_clk_oe_n;
      out_nxt[PIN_TW_DAT] = 1'b0;
      drv_nxt[PIN_TW_DAT] = !PERIPH.tw_dat_oe_n;
    end
    if (FUNC.spi_en) begin
      // Select and clock stay with the serial port when test owns pins 3/4
      out_nxt[PIN_SEL] = PERIPH.spi_sel;
      drv_nxt[PIN_SEL] = FUNC.spi_master && FUNC.spi_dma;
      out_nxt[PIN_SCK] = PERIPH.spi_sck;
      drv_nxt[PIN_SCK] = FUNC.spi_master;
    end
    if (FUNC.test_en) begin
      out_nxt[PIN_TX] = PERIPH.test_out_zero;
      drv_nxt[PIN_TX] = 1'b1;
      out_nxt[PIN_RX] = PERIPH.test_out_one;
      drv_nxt[PIN_RX] = 1'b1;
    end else if (FUNC.spi_en) begin
      out_nxt[PIN_TX]  = PERIPH.spi_mosi;
      drv_nxt[PIN_TX]  = FUNC.spi_master;
      out_nxt[PIN_RX]  = PERIPH.spi_miso;
      drv_nxt[PIN_RX]  = !FUNC.spi_master;
    end else if (FUNC.uart_en) begin
      out_nxt[PIN_TX] = PERIPH.uart_txd;
      drv_nxt[PIN_TX] = 1'b1;
      out_nxt[PIN_RX] = PERIPH.uart_rxclk;
      drv_nxt[PIN_RX] = FUNC.uart_mode0;
    end
    if (FUNC.pulse_timer_en) begin
      out_nxt[PIN_SEL] = PERIPH.pulse_channel_zero;
      drv_nxt[PIN_SEL] = 1'b1;
      if (!mid_pins_taken(FUNC)) begin
        out_nxt[PIN_RX] = PERIPH.pulse_channel_one;
        drv_nxt[PIN_RX] = 1'b1;
      end
    end
    if (FUNC.radio_tx_pin_enable) begin
      out_nxt[PIN_SEL] = PERIPH.radio_bit;
      drv_nxt[PIN_SEL] = 1'b1;
    end
  end

  // ----------------------------------------
  // Registered pin and status outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PIN_OUT       <= 6'h00;
      PIN_OE_N      <= 6'h3F;
      PIN_PULL_UP   <= 6'h00;
      PIN_PULL_DOWN <= 6'h00;
    end else begin
      PIN_OUT       <= out_nxt;
      PIN_OE_N      <= ~drv_nxt;
      PIN_PULL_UP   <= pu_nxt;
      PIN_PULL_DOWN <= cfg_r.pull_down;
    end
  end

  // Readback of configuration and pin levels
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CFG_RD_DATA <= '0;
      PIN_STATE   <= 6'h00;
    end else begin
      CFG_RD_DATA <= cfg_r;
      PIN_STATE   <= sync2_r;
    end
  end

  // ----------------------------------------
  // Boot mode status
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      BOOT_MODE  <= GPM_BOOT_NORMAL;
      BOOT_VALID <= 1'b0;
    end else begin
      BOOT_MODE  <= boot_r;
      BOOT_VALID <= (state_r == GPM_ST_RUN);
    end
  end

  // ----------------------------------------
  // Wake detection
  // ----------------------------------------
  // Any level change on a wake-enabled pin, after synchronisation
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= |((sync2_r ^ prev_r) & cfg_r.wake_en);
    end
  end

  // ----------------------------------------
  // Pin levels toward peripherals
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      PERIPH_IN <= '0;
    end else begin
      PERIPH_IN.tw_clk   <= sync2_r[PIN_TW_CLK];
      PERIPH_IN.tw_dat   <= sync2_r[PIN_TW_DAT];
      PERIPH_IN.uart_rxd <= sync2_r[PIN_RX];
      PERIPH_IN.spi_sel  <= sync2_r[PIN_SEL];
      PERIPH_IN.spi_mosi <= sync2_r[PIN_TX];
      PERIPH_IN.spi_miso <= sync2_r[PIN_RX];
      PERIPH_IN.spi_sck  <= sync2_r[PIN_SCK];
      PERIPH_IN.external_system_clock_in <= sync2_r[PIN_SCK];
    end
  end

endmodule

// ---- dv/gpm_port_checker.sv ----
// Concurrent checks on the port multiplexer top-level ports
`timescale 1ns/1ns
module gpm_port_checker (
  input wire logic                 CORE_CLK,
  input wire logic                 NRST,
  input wire gpm_pkg::gpm_cfg_t    CFG_WR_DATA,
  input wire logic                 CFG_WR,
  input wire logic                 LOW_POWER,
  input wire gpm_pkg::gpm_func_t   FUNC,
  input wire gpm_pkg::gpm_periph_t PERIPH,
  input wire logic [5:0]           PIN_OUT,
  input wire logic [5:0]           PIN_OE_N,
  input wire gpm_pkg::gpm_cfg_t    CFG_RD_DATA,
  input wire logic [1:0]           BOOT_MODE,
  input wire logic                 BOOT_VALID
);
  import gpm_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence wr_taken;
    CFG_WR && !LOW_POWER;
  endsequence
  cfg_store_a: assert property (wr_taken |-> ##2 CFG_RD_DATA == $past(CFG_WR_DATA, 2))
    else $error("config write not stored");
  cfg_freeze_a: assert property (LOW_POWER |-> ##2 $stable(CFG_RD_DATA))
    else $error("config changed in low power");
  twowire_pins_a: assert property (FUNC.twowire_port_enable |=>
    PIN_OE_N[1:0] == $past({PERIPH.tw_dat_oe_n, PERIPH.tw_clk_oe_n})) else $error("two-wire pins");
  uart_tx_a: assert property (FUNC.uart_en && !FUNC.spi_en && !FUNC.test_en |=>
    !PIN_OE_N[3] && PIN_OUT[3] == $past(PERIPH.uart_txd)) else $error("uart transmit pin");
  rx_clock_a: assert property (FUNC.uart_en && FUNC.uart_mode0 && !FUNC.spi_en
    && !FUNC.test_en |=> !PIN_OE_N[4] && PIN_OUT[4] == $past(PERIPH.uart_rxclk))
    else $error("rx clock pin");
  spi_data_dir_a: assert property (FUNC.spi_en && !FUNC.test_en |=>
    PIN_OE_N[4:3] == $past({FUNC.spi_master, !FUNC.spi_master})) else $error("serial data dir");
  spi_clock_a: assert property (FUNC.spi_en |=> PIN_OE_N[5] == !$past(FUNC.spi_master))
    else $error("serial clock direction");
  radio_out_a: assert property (FUNC.radio_tx_pin_enable |=>
    !PIN_OE_N[2] && PIN_OUT[2] == $past(PERIPH.radio_bit)) else $error("radio pin");
  test_out_a: assert property (FUNC.test_en |=>
    PIN_OUT[4:3] == $past({PERIPH.test_out_one, PERIPH.test_out_zero})) else $error("test pins");
  boot_hold_a: assert property (BOOT_VALID |=> BOOT_VALID && $stable(BOOT_MODE))
    else $error("boot mode not held");
endmodule
bind gpm_port_mux gpm_port_checker u_chk (.CORE_CLK, .NRST, .CFG_WR_DATA, .CFG_WR, .LOW_POWER,
  .FUNC, .PERIPH, .PIN_OUT, .PIN_OE_N, .CFG_RD_DATA, .BOOT_MODE, .BOOT_VALID);

// ---- dv/gpm_pin_model.sv ----
// Board-side model of the six pins: tools, pulls, floating lines
`timescale 1ns/1ns
module gpm_pin_model (
  input  wire logic       CORE_CLK,
  input  wire logic [5:0] PIN_OUT,
  input  wire logic [5:0] PIN_OE_N,
  input  wire logic [5:0] PIN_PULL_UP,
  input  wire logic [5:0] PIN_PULL_DOWN,
  input  wire logic [5:0] EXT_OE,
  input  wire logic [5:0] EXT_VAL,
  output logic [5:0]      PIN_IN
);
  logic [5:0] float_r = 6'h15;
  // Undriven lines wander every cycle
  always_ff @(posedge CORE_CLK) float_r <= ~float_r;
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      if (!PIN_OE_N[p]) PIN_IN[p] = PIN_OUT[p];
      else if (EXT_OE[p]) PIN_IN[p] = EXT_VAL[p];
      else if (PIN_PULL_UP[p]) PIN_IN[p] = 1'b1;
      else if (PIN_PULL_DOWN[p]) PIN_IN[p] = 1'b0;
      else PIN_IN[p] = float_r[p];
    end
  end
endmodule

// ---- dv/gpio_port_function_mux_tb_top.sv ----
// Self-checking bench for the port multiplexer
`timescale 1ns/1ns
module gpio_port_function_mux_tb_top;
  import gpm_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cfg_wr = 1'b0;
  logic        low_power = 1'b0;
  gpm_cfg_t    cfg = '0;
  gpm_cfg_t    cfg_rd;
  gpm_func_t   func = '0;
  gpm_periph_t periph = '0;
  logic [5:0]  ext_oe = 6'h03, ext_val = 6'h01;
  logic [5:0]  pin_in, pin_out, pin_oe_n, pu, pd, pin_state;
  logic [1:0]  boot_mode;
  logic        boot_valid, wake;
  int          failures = 0, checks = 0, i;
  logic [1:0]  st[3] = '{2'h1, 2'h2, 2'h3};
  logic [1:0]  bm[3] = '{2'h1, 2'h2, 2'h0};
  logic [20:0] fn[10] = '{21'h080637, 21'h0C0627, 21'h030F17, 21'h038F13, 21'h020F2F,
                          21'h00452B, 21'h00213B, 21'h001627, 21'h10003C, 21'h031F07};
  always #4 core_clk = ~core_clk;
  gpm_port_mux dut (.CORE_CLK(core_clk), .NRST(nrst), .CFG_WR_DATA(cfg), .CFG_WR(cfg_wr),
    .LOW_POWER(low_power), .FUNC(func), .PERIPH(periph), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_N(pin_oe_n), .PIN_PULL_UP(pu), .PIN_PULL_DOWN(pd), .CFG_RD_DATA(cfg_rd),
    .PIN_STATE(pin_state), .PERIPH_IN(), .BOOT_MODE(boot_mode), .BOOT_VALID(boot_valid),
    .WAKE(wake));
  gpm_pin_model pins (.CORE_CLK(core_clk), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .PIN_PULL_UP(pu), .PIN_PULL_DOWN(pd), .EXT_OE(ext_oe), .EXT_VAL(ext_val), .PIN_IN(pin_in));
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic boot(input logic [1:0] strap);
    nrst <= 1'b0;
    ext_oe <= 6'h03;
    ext_val <= {4'h0, strap};
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 20 && boot_valid !== 1'b1; i++) @(posedge core_clk);
    if (i == 20) begin
      failures++;
      results();
    end
  endtask
  task automatic wr(input gpm_cfg_t c);
    @(posedge core_clk);
    cfg <= c;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  initial begin
    foreach (st[k]) begin
      boot(st[k]);
      chk({4'h0, boot_mode}, {4'h0, bm[k]});
    end
    ext_oe <= 6'h00;
    wr({6'h2A, 6'h3F, 6'h15, 6'h2A, 6'h00});
    chk(pin_out, 6'h2A);
    chk(pin_oe_n, 6'h00);
    chk(pu, 6'h15);
    chk(pd, 6'h2A);
    chk(cfg_rd.data, 6'h2A);
    @(posedge core_clk);
    ext_oe <= 6'h3F;
    ext_val <= 6'h2D;
    wr({24'h0, 6'h3F});
    repeat (2) @(posedge core_clk);
    #1;
    chk(pin_state, 6'h2D);
    chk({5'h00, wake}, 6'h01);
    @(posedge core_clk);
    ext_val <= 6'h2C;
    @(negedge core_clk);
    chk({5'h00, wake}, 6'h00);
    for (i = 0; i < 8 && wake !== 1'b1; i++) @(negedge core_clk);
    chk({5'h00, wake}, 6'h01);
    @(posedge core_clk);
    low_power <= 1'b1;
    wr(30'h3FFFFFFF);
    chk(cfg_rd.data, 6'h00);
    chk(pin_oe_n, 6'h3F);
    @(posedge core_clk);
    low_power <= 1'b0;
    foreach (fn[k]) begin
      @(posedge core_clk);
      func <= fn[k][20:12];
      periph <= fn[k][20] ? '0 : '1;
      repeat (2) @(posedge core_clk);
      #1;
      chk(pin_oe_n, fn[k][5:0]);
      chk(pin_out, fn[k][11:6]);
    end
    results();
  end
endmodule
